// >>> ssg_pkg.sv
// constants for the system-control scratch, pin and bus status register bank
package ssg_pkg;

    // bus geometry
    localparam int          DATA_W          = 32;
    localparam int          ADDR_W          = 12;
    localparam int          SEL_W           = DATA_W / 8;
    localparam int          PIN_COUNT       = 16;
    localparam int          BUS_ADDR_W      = 7;

    // register byte offsets
    localparam logic [11:0] OFF_SCRATCH     = 12'h40c;
    localparam logic [11:0] OFF_ALT_SEL     = 12'h418;
    localparam logic [11:0] OFF_DIR         = 12'h41c;
    localparam logic [11:0] OFF_LEVEL       = 12'h420;
    localparam logic [11:0] OFF_STATUS      = 12'h424;
    localparam logic [11:0] OFF_IRQ_MASK    = 12'h440;

    // reset values
    localparam logic [31:0] RST_SCRATCH     = 32'h0000_0000;
    localparam logic [15:0] RST_PIN_FIELD   = 16'h0000;
    localparam logic [6:0]  RST_BUS_ADDR    = 7'h00;

    // status field positions
    localparam int          TGT_ADDR_LSB    = 1;
    localparam int          CTL_ADDR_LSB    = 9;
    localparam int          LOAD_DONE_BIT   = 24;
    localparam int          ERR_LSB         = 25;
    localparam int          ERR_W           = 5;
    localparam int          ERR_NACK        = 0;
    localparam int          ERR_ARB         = 1;
    localparam int          ERR_COND        = 2;
    localparam int          ERR_CSUM        = 3;
    localparam int          ERR_UNMAP       = 4;
    localparam logic [4:0]  RST_ERR         = 5'h00;

    // arbitration retry limit
    localparam int          ARB_LOSS_LIMIT  = 16;
    localparam int          ARB_CNT_W       = 5;
    localparam logic [4:0]  ARB_CNT_ZERO    = 5'h00;
    localparam logic [4:0]  ARB_CNT_LAST    = 5'(ARB_LOSS_LIMIT - 1);

endpackage : ssg_pkg

// >>> ssg_sysctl_regs.sv
// system-control register bank: scratch word, pin control and bus status flags
//
// Summary of operation
// - 32-bit scratch word, resets to zero, reads back last write, no side effect.
// - sticky alternate-select bit per pin: one routes alternate function, zero plain pin.
// - sticky direction bit in plain mode: set drives output, clear is input.
// - alternate-mode pins ignore direction bit; alternate function decides drive.
// - pin data read returns live level of all sixteen pins.
// - pin data write drives only plain output pins; other pins unaffected.
// - status bits 7:1 show hardware-assigned target-side bus address, read-only.
// - status bits 15:9 show hardware-assigned controller-side bus address, read-only.
// - bit 24 sets when boot-time configuration load finishes or hits a checksum error.
// - bit 25 sets on unexpected not-acknowledge; write one clears it.
// - arbitration losses retry; sixteenth consecutive loss aborts and sets bit 26.
// - bit 27 sets on misplaced start or stop condition; write one clears.
// - bit 28 sets on bad load checksum or missing done command.
// - bit 29 sets when load targets an absent register; write one clears.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ns
module ssg_sysctl_regs
    import ssg_pkg::*;
#(
    parameter int PIN_W = PIN_COUNT
) (
    // clock and resets
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  soft_rst,
    // wishbone slave
    input  wire logic                  wb_cyc,
    input  wire logic                  wb_stb,
    input  wire logic                  wb_we,
    input  wire logic [ADDR_W-1:0]     wb_adr,
    input  wire logic [SEL_W-1:0]      wb_sel,
    input  wire logic [DATA_W-1:0]     wb_dat_w,
    output logic      [DATA_W-1:0]     wb_dat_r,
    output logic                       wb_ack,
    // pins
    input  wire logic [PIN_W-1:0]      pin_in,
    output logic      [PIN_W-1:0]      pin_out,
    output logic      [PIN_W-1:0]      pin_oe_n,
    // alternate functions
    input  wire logic [PIN_W-1:0]      alt_out,
    input  wire logic [PIN_W-1:0]      alt_oe_n,
    // hardware-assigned bus addresses
    input  wire logic                  bus_addr_load,
    input  wire logic [BUS_ADDR_W-1:0] target_side_bus_address,
    input  wire logic [BUS_ADDR_W-1:0] controller_side_bus_address,
    // controller-side bus engine events
    input  wire logic                  nack_event,
    input  wire logic                  arb_lost_event,
    input  wire logic                  arb_won_event,
    input  wire logic                  misplaced_cond_event,
    output logic                       arb_abort,
    // configuration loader events
    input  wire logic                  eeprom_boot_mode,
    input  wire logic                  load_finished_event,
    input  wire logic                  load_checksum_event,
    input  wire logic                  unmapped_target_event,
    // interrupt
    output logic                       irq
);

    // byte-lane mask from select lines
    function automatic logic [DATA_W-1:0] lane_mask(input logic [SEL_W-1:0] sel);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < SEL_W; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction : lane_mask

    // word address match
    function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [11:0] off);
        return adr[ADDR_W-1:2] == off[ADDR_W-1:2];
    endfunction : reg_hit

    // state
    logic [DATA_W-1:0]     scratch_word_register_q;
    logic [PIN_W-1:0]      pin_alt_select_bits_q;
    logic [PIN_W-1:0]      pin_direction_bits_q;
    logic [PIN_W-1:0]      pin_level_bits_q;
    logic [BUS_ADDR_W-1:0] tgt_addr_q;
    logic [BUS_ADDR_W-1:0] ctl_addr_q;
    logic                  config_load_done_q;
    logic [ERR_W-1:0]      err_q;
    logic [ERR_W-1:0]      irq_mask_q;
    logic [ARB_CNT_W-1:0]  arb_cnt_q;
    logic                  arb_abort_q;
    logic                  ack_q;
    logic [DATA_W-1:0]     rdata_q;
    logic [PIN_W-1:0]      pin_out_q;
    logic [PIN_W-1:0]      pin_oe_n_q;
    logic                  irq_q;

    // bus decode
    wire logic              req        = wb_cyc && wb_stb && !ack_q;
    wire logic              wr         = req && wb_we;
    wire logic [DATA_W-1:0] be         = lane_mask(wb_sel);
    wire logic              hit_scr    = reg_hit(wb_adr, OFF_SCRATCH);
    wire logic              hit_alt    = reg_hit(wb_adr, OFF_ALT_SEL);
    wire logic              hit_dir    = reg_hit(wb_adr, OFF_DIR);
    wire logic              hit_lvl    = reg_hit(wb_adr, OFF_LEVEL);
    wire logic              hit_sts    = reg_hit(wb_adr, OFF_STATUS);
    wire logic              hit_msk    = reg_hit(wb_adr, OFF_IRQ_MASK);
    wire logic [DATA_W-1:0] wmerge_scr = (scratch_word_register_q & ~be) | (wb_dat_w & be);
    wire logic [DATA_W-1:0] wbits      = wb_dat_w & be;

    // pin modes
    wire logic [PIN_W-1:0]  plain_out  = ~pin_alt_select_bits_q & pin_direction_bits_q;
    wire logic [PIN_W-1:0]  lvl_wmask  = plain_out & be[PIN_W-1:0];
    wire logic [PIN_W-1:0]  alt_wmask  = be[PIN_W-1:0];

    // next values of the pin control fields
    wire logic [PIN_W-1:0]  alt_sel_d  = (wr && hit_alt)
                                       ? ((pin_alt_select_bits_q & ~alt_wmask) | (wbits[PIN_W-1:0]))
                                       : pin_alt_select_bits_q;
    wire logic [PIN_W-1:0]  dir_d      = (wr && hit_dir)
                                       ? ((pin_direction_bits_q & ~alt_wmask) | (wbits[PIN_W-1:0]))
                                       : pin_direction_bits_q;
    wire logic [PIN_W-1:0]  level_d    = (wr && hit_lvl)
                                       ? ((pin_level_bits_q & ~lvl_wmask) | (wb_dat_w[PIN_W-1:0] & lvl_wmask))
                                       : pin_level_bits_q;

    // pin drivers: alternate mode follows the alternate function
    wire logic [PIN_W-1:0]  pin_out_d  = (pin_alt_select_bits_q & alt_out)
                                       | (~pin_alt_select_bits_q & pin_level_bits_q);
    wire logic [PIN_W-1:0]  pin_oe_n_d = (pin_alt_select_bits_q & alt_oe_n)
                                       | (~pin_alt_select_bits_q & ~pin_direction_bits_q);

    // arbitration loss counting
    wire logic              arb_limit  = arb_lost_event && (arb_cnt_q == ARB_CNT_LAST);
    wire logic [ARB_CNT_W-1:0] arb_cnt_d = (arb_won_event || arb_limit) ? ARB_CNT_ZERO
                                       : arb_lost_event ? arb_cnt_q + 5'h01
                                       : arb_cnt_q;

    // error events and write-one-to-clear; set wins over clear
    wire logic [ERR_W-1:0]  err_set;
    assign err_set[ERR_NACK]  = nack_event;
    assign err_set[ERR_ARB]   = arb_limit;
    assign err_set[ERR_COND]  = misplaced_cond_event;
    assign err_set[ERR_CSUM]  = load_checksum_event;
    assign err_set[ERR_UNMAP] = unmapped_target_event;
    wire logic [ERR_W-1:0]  err_clr    = (wr && hit_sts) ? wbits[ERR_LSB +: ERR_W] : RST_ERR;
    wire logic [ERR_W-1:0]  err_d      = (err_q & ~err_clr) | err_set;
    wire logic [ERR_W-1:0]  mask_d     = (wr && hit_msk)
                                       ? ((irq_mask_q & ~be[ERR_LSB +: ERR_W]) | wbits[ERR_LSB +: ERR_W])
                                       : irq_mask_q;

    // load done
    wire logic              load_done_d = config_load_done_q
                                       || (eeprom_boot_mode && (load_finished_event || load_checksum_event));

    // status word
    wire logic [DATA_W-1:0] status_word;
    assign status_word[0]                                = 1'h0;
    assign status_word[TGT_ADDR_LSB +: BUS_ADDR_W]       = tgt_addr_q;
    assign status_word[CTL_ADDR_LSB - 1]                 = 1'h0;
    assign status_word[CTL_ADDR_LSB +: BUS_ADDR_W]       = ctl_addr_q;
    assign status_word[LOAD_DONE_BIT-1:CTL_ADDR_LSB+BUS_ADDR_W] = 8'h00;
    assign status_word[LOAD_DONE_BIT]                    = config_load_done_q;
    assign status_word[ERR_LSB +: ERR_W]                 = err_q;
    assign status_word[DATA_W-1:ERR_LSB+ERR_W]           = 2'h0;

    wire logic [DATA_W-1:0] mask_word  = DATA_W'({irq_mask_q, {ERR_LSB{1'b0}}});

    // read mux; unmapped addresses answer zero
    wire logic [DATA_W-1:0] rdata_d    = hit_scr ? scratch_word_register_q
                                       : hit_alt ? DATA_W'(pin_alt_select_bits_q)
                                       : hit_dir ? DATA_W'(pin_direction_bits_q)
                                       : hit_lvl ? DATA_W'(pin_in)
                                       : hit_sts ? status_word
                                       : hit_msk ? mask_word
                                       : 32'h0000_0000;

    // bus answer
    always_ff @(posedge clock) begin
        if (rst || soft_rst) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= req;
            rdata_q <= req ? rdata_d : rdata_q;
        end
    end

    // non-sticky registers
    always_ff @(posedge clock) begin
        if (rst || soft_rst) begin
            scratch_word_register_q <= RST_SCRATCH;
            err_q                   <= RST_ERR;
            irq_mask_q              <= RST_ERR;
            arb_cnt_q               <= ARB_CNT_ZERO;
            arb_abort_q             <= 1'b0;
            irq_q                   <= 1'b0;
        end else begin
            scratch_word_register_q <= (wr && hit_scr) ? wmerge_scr : scratch_word_register_q;
            err_q                   <= err_d;
            irq_mask_q              <= mask_d;
            arb_cnt_q               <= arb_cnt_d;
            arb_abort_q             <= arb_limit;
            irq_q                   <= |(err_d & mask_d);
        end
    end

    // sticky registers survive the soft reset
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_alt_select_bits_q <= RST_PIN_FIELD;
            pin_direction_bits_q  <= RST_PIN_FIELD;
            pin_level_bits_q      <= RST_PIN_FIELD;
            pin_out_q             <= RST_PIN_FIELD;
            pin_oe_n_q            <= ~RST_PIN_FIELD;
        end else begin
            pin_alt_select_bits_q <= alt_sel_d;
            pin_direction_bits_q  <= dir_d;
            pin_level_bits_q      <= level_d;
            pin_out_q             <= pin_out_d;
            pin_oe_n_q            <= pin_oe_n_d;
        end
    end

    // hardware-initialised fields, cleared only by the full reset
    always_ff @(posedge clock) begin
        if (rst) begin
            tgt_addr_q         <= RST_BUS_ADDR;
            ctl_addr_q         <= RST_BUS_ADDR;
            config_load_done_q <= 1'b0;
        end else begin
            tgt_addr_q         <= bus_addr_load ? target_side_bus_address : tgt_addr_q;
            ctl_addr_q         <= bus_addr_load ? controller_side_bus_address : ctl_addr_q;
            config_load_done_q <= load_done_d;
        end
    end

    // outputs
    assign wb_ack    = ack_q;
    assign wb_dat_r  = rdata_q;
    assign pin_out   = pin_out_q;
    assign pin_oe_n  = pin_oe_n_q;
    assign arb_abort = arb_abort_q;
    assign irq       = irq_q;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || soft_rst);

    sequence seq_write(logic hit);
        wb_cyc && wb_stb && wb_we && !ack_q && hit;
    endsequence

    sequence seq_read(logic hit);
        wb_cyc && wb_stb && !wb_we && !ack_q && hit;
    endsequence

    AST_SCRATCH_HOLD: assert property (!(wr && hit_scr) |=> $stable(scratch_word_register_q))
        else $error("scratch word changed without a write");

    AST_SCRATCH_READBACK: assert property (
        seq_write(hit_scr && &wb_sel) ##3 seq_read(hit_scr) |=> wb_ack && wb_dat_r == $past(wb_dat_w, 4))
        else $error("scratch word did not read back the last write");

    AST_ALT_ROUTE: assert property (
        pin_alt_select_bits_q[0] |=> pin_out[0] == $past(alt_out[0]) && pin_oe_n[0] == $past(alt_oe_n[0]))
        else $error("alternate-mode pin not following its function");

    AST_DIR_PLAIN: assert property (
        !pin_alt_select_bits_q[0] |=> pin_oe_n[0] == !$past(pin_direction_bits_q[0]))
        else $error("plain pin drive enable disagrees with direction bit");

    AST_DIR_IGNORED: assert property (
        pin_alt_select_bits_q[0] && alt_oe_n[0] && pin_direction_bits_q[0] |=> pin_oe_n[0])
        else $error("direction bit drove an alternate-mode pin");

    AST_READ_PINS: assert property (seq_read(hit_lvl) |=> wb_ack && wb_dat_r == DATA_W'($past(pin_in)))
        else $error("pin data read did not return live pin levels");

    AST_LEVEL_KEEP: assert property (
        seq_write(hit_lvl) |=> (pin_level_bits_q & ~$past(plain_out)) == ($past(pin_level_bits_q) & ~$past(plain_out)))
        else $error("pin data write changed a pin not in plain output mode");

    AST_ADDR_RO: assert property (
        seq_write(hit_sts && !bus_addr_load) |=> $stable(tgt_addr_q) && $stable(ctl_addr_q))
        else $error("bus address field changed by software");

    AST_LOAD_DONE: assert property (eeprom_boot_mode && load_finished_event |=> status_word[LOAD_DONE_BIT])
        else $error("load done not set after load finished");

    AST_NACK_W0: assert property (
        seq_write(hit_sts && err_q[ERR_NACK] && !nack_event && !wb_dat_w[ERR_LSB + ERR_NACK]) |=> err_q[ERR_NACK])
        else $error("writing zero cleared the not-acknowledge flag");

    AST_NACK_SET: assert property (nack_event |=> err_q[ERR_NACK] ##1 (irq || !irq_mask_q[ERR_NACK]))
        else $error("not-acknowledge event lost");

    AST_ARB_ABORT: assert property (arb_lost_event && arb_cnt_q == ARB_CNT_LAST |=> arb_abort && err_q[ERR_ARB] && arb_cnt_q == ARB_CNT_ZERO)
        else $error("sixteenth arbitration loss did not abort");

    AST_ARB_EARLY: assert property (arb_cnt_q != ARB_CNT_LAST |=> !arb_abort)
        else $error("abort before sixteen consecutive losses");

    AST_COND_SET: assert property (misplaced_cond_event |=> err_q[ERR_COND])
        else $error("misplaced condition flag not set");

    AST_CSUM_SET: assert property (load_checksum_event |=> err_q[ERR_CSUM])
        else $error("checksum error flag not set");

    AST_UNMAP_SET: assert property (unmapped_target_event |=> err_q[ERR_UNMAP])
        else $error("unmapped load target flag not set");

    AST_RESERVED_ZERO: assert property (seq_read(hit_alt || hit_dir || hit_lvl) |=> wb_ack && wb_dat_r[DATA_W-1:PIN_W] == '0)
        else $error("reserved bits read nonzero");

    AST_ACK_PULSE: assert property (wb_ack |=> !wb_ack)
        else $error("ack held for more than one cycle");

    AST_W1C_CLEAR: assert property (
        seq_write(hit_sts && be[ERR_LSB + ERR_NACK] && wb_dat_w[ERR_LSB + ERR_NACK] && !nack_event)
            |=> !err_q[ERR_NACK])
        else $error("writing one did not clear the not-acknowledge flag");

    AST_ARB_COUNT: assert property (
        arb_lost_event && !arb_won_event && arb_cnt_q != ARB_CNT_LAST |=> arb_cnt_q == $past(arb_cnt_q) + 5'h01)
        else $error("consecutive arbitration loss not counted");

    AST_ARB_WON_CLEAR: assert property (arb_won_event |=> arb_cnt_q == ARB_CNT_ZERO)
        else $error("won arbitration did not restart the loss count");

    AST_ARB_FLAG_ONLY: assert property (
        !err_q[ERR_ARB] && !(arb_lost_event && arb_cnt_q == ARB_CNT_LAST) |=> !err_q[ERR_ARB])
        else $error("arbitration flag set without sixteen losses");

    AST_LEVEL_WRITE: assert property (
        seq_write(hit_lvl && &be[PIN_W-1:0]) |=> pin_level_bits_q
            == (($past(pin_level_bits_q) & ~$past(plain_out)) | ($past(wb_dat_w[PIN_W-1:0]) & $past(plain_out))))
        else $error("pin data write did not reach plain output pins");

    AST_LOAD_DONE_STICKY: assert property (config_load_done_q |=> config_load_done_q)
        else $error("load done bit fell without full reset");

    AST_STATUS_RESERVED: assert property (
        seq_read(hit_sts) |=> wb_ack && !wb_dat_r[TGT_ADDR_LSB - 1] && !wb_dat_r[CTL_ADDR_LSB - 1]
            && wb_dat_r[LOAD_DONE_BIT-1:CTL_ADDR_LSB+BUS_ADDR_W] == 8'h00
            && wb_dat_r[DATA_W-1:ERR_LSB+ERR_W] == 2'h0)
        else $error("reserved status bits read nonzero");

    AST_IRQ_LEVEL: assert property (irq == |(err_q & irq_mask_q))
        else $error("interrupt level disagrees with flags and mask");

endmodule : ssg_sysctl_regs

// >>> tb_top.sv
// self-checking bench for the system-control register bank
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, (exp), (got)); end end
module tb_top
    import ssg_pkg::*;
;
    logic                  clock, rst, soft_rst, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [ADDR_W-1:0]     wb_adr;
    logic [SEL_W-1:0]      wb_sel;
    logic [DATA_W-1:0]     wb_dat_w, wb_dat_r, rdat;
    logic [PIN_COUNT-1:0]  pin_in, pin_out, pin_oe_n, alt_out, alt_oe_n;
    logic [BUS_ADDR_W-1:0] tgt_addr, ctl_addr;
    logic [4:0]            ev;
    logic                  bus_addr_load, arb_won, arb_abort, boot_mode, load_done_ev, irq;
    int                    miscompares, samples_checked, abort_seen;

    ssg_sysctl_regs u_ssg_sysctl_regs (
        .clock(clock), .rst(rst), .soft_rst(soft_rst),
        .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .alt_out(alt_out), .alt_oe_n(alt_oe_n),
        .bus_addr_load(bus_addr_load), .target_side_bus_address(tgt_addr),
        .controller_side_bus_address(ctl_addr),
        .nack_event(ev[ERR_NACK]), .arb_lost_event(ev[ERR_ARB]), .arb_won_event(arb_won),
        .misplaced_cond_event(ev[ERR_COND]), .arb_abort(arb_abort), .eeprom_boot_mode(boot_mode),
        .load_finished_event(load_done_ev), .load_checksum_event(ev[ERR_CSUM]),
        .unmapped_target_event(ev[ERR_UNMAP]), .irq(irq)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) if (arb_abort === 1'b1) abort_seen <= abort_seen + 1;

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] wd, input logic [3:0] sel);
        int n;
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= adr;
        wb_sel   <= sel;
        wb_dat_w <= wd;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rdat = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (wb_ack !== 1'b1) begin
            miscompares++;
            summarize();
        end
        @(posedge clock);
    endtask : bus

    task automatic wr(input logic [11:0] adr, input logic [31:0] wd);
        bus(1'b1, adr, wd, 4'hf);
    endtask : wr

    task automatic rchk(input logic [11:0] adr, input logic [31:0] exp, input string nm);
        bus(1'b0, adr, 32'h0, 4'hf);
        `CHK(nm, exp, rdat)
    endtask : rchk

    task automatic pulse_ev(input int k);
        ev[k] <= 1'b1;
        @(posedge clock);
        ev[k] <= 1'b0;
        @(posedge clock);
    endtask : pulse_ev

    task automatic t_scratch();
        rchk(OFF_SCRATCH, RST_SCRATCH, "scratch reset");
        rchk(OFF_ALT_SEL, 32'h0, "alt reset");
        rchk(OFF_DIR, 32'h0, "dir reset");
        `CHK("oe_n reset", 16'hffff, pin_oe_n)
        wr(OFF_SCRATCH, 32'ha5a5_5a5a);
        rchk(OFF_SCRATCH, 32'ha5a5_5a5a, "scratch word");
        bus(1'b1, OFF_SCRATCH, 32'hffff_ffff, 4'h1);
        rchk(OFF_SCRATCH, 32'ha5a5_5aff, "scratch lanes");
        wr(OFF_ALT_SEL, 32'hffff_ffff);
        rchk(OFF_ALT_SEL, 32'h0000_ffff, "alt reserved");
        wr(12'h410, 32'h1234_5678);
        rchk(12'h410, 32'h0, "unmapped");
        wr(OFF_ALT_SEL, 32'h0000_000f);
        wr(OFF_DIR, 32'h0000_00ff);
        soft_rst <= 1'b1;
        @(posedge clock);
        soft_rst <= 1'b0;
        @(posedge clock);
        rchk(OFF_SCRATCH, 32'h0, "scratch soft reset");
        rchk(OFF_ALT_SEL, 32'h0000_000f, "alt sticky");
        rchk(OFF_DIR, 32'h0000_00ff, "dir sticky");
    endtask : t_scratch

    task automatic t_pins();
        alt_out  <= 16'h0005;
        alt_oe_n <= 16'h000a;
        wr(OFF_LEVEL, 32'hffff_ffff);
        @(posedge clock);
        `CHK("oe_n mixed", 16'hff0a, pin_oe_n)
        `CHK("out mixed", 16'h00f5, pin_out)
        wr(OFF_DIR, 32'h0000_ffff);
        @(posedge clock);
        `CHK("oe_n alt ignores dir", 16'h000a, pin_oe_n)
        `CHK("out inputs untouched", 16'h00f5, pin_out)
        pin_in <= 16'h3c96;
        repeat (2) @(posedge clock);
        rchk(OFF_LEVEL, 32'h0000_3c96, "pin read");
    endtask : t_pins

    task automatic t_status();
        tgt_addr      <= 7'h5a;
        ctl_addr      <= 7'h33;
        bus_addr_load <= 1'b1;
        @(posedge clock);
        bus_addr_load <= 1'b0;
        wr(OFF_STATUS, 32'hffff_ffff);
        rchk(OFF_STATUS, 32'h0000_66b4, "bus addresses");
        load_done_ev <= 1'b1;
        @(posedge clock);
        load_done_ev <= 1'b0;
        rchk(OFF_STATUS, 32'h0000_66b4, "done without boot load");
        boot_mode    <= 1'b1;
        load_done_ev <= 1'b1;
        @(posedge clock);
        load_done_ev <= 1'b0;
        wr(OFF_STATUS, 32'hffff_ffff);
        rchk(OFF_STATUS, 32'h0100_66b4, "load done");
    endtask : t_status

    task automatic t_errors();
        wr(OFF_IRQ_MASK, 32'h3e00_0000);
        for (int k = 0; k < ERR_W; k++) begin
            if (k == ERR_ARB) continue;
            pulse_ev(k);
            `CHK("irq on flag", 1'b1, irq)
            wr(OFF_STATUS, 32'h0);
            rchk(OFF_STATUS, 32'h0100_66b4 | (32'h1 << (ERR_LSB + k)), "flag set");
            wr(OFF_STATUS, 32'h1 << (ERR_LSB + k));
            rchk(OFF_STATUS, 32'h0100_66b4, "flag cleared");
            `CHK("irq cleared", 1'b0, irq)
        end
        wr(OFF_IRQ_MASK, 32'h0);
        pulse_ev(ERR_NACK);
        `CHK("irq masked", 1'b0, irq)
        wr(OFF_IRQ_MASK, 32'h0200_0000);
        `CHK("irq unmasked", 1'b1, irq)
        wr(OFF_STATUS, 32'h0200_0000);
        `CHK("irq after clear", 1'b0, irq)
    endtask : t_errors

    task automatic t_arb(input int losses, input int aborts);
        ev[ERR_ARB] <= 1'b1;
        repeat (losses) @(posedge clock);
        ev[ERR_ARB] <= 1'b0;
        arb_won     <= 1'b1;
        @(posedge clock);
        arb_won <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK("abort count", aborts, abort_seen)
    endtask : t_arb

    initial begin
        miscompares = 0;
        samples_checked = 0;
        abort_seen = 0;
        {rst, soft_rst, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = {1'b1, 52'h0};
        {pin_in, alt_out, alt_oe_n, tgt_addr, ctl_addr, ev} = {32'h0, 16'hffff, 19'h0};
        {bus_addr_load, arb_won, boot_mode, load_done_ev} = 4'h0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_scratch();
        t_pins();
        t_status();
        t_errors();
        t_arb(15, 0);
        t_arb(15, 0);
        rchk(OFF_STATUS, 32'h0100_66b4, "no arb flag");
        t_arb(16, 1);
        rchk(OFF_STATUS, 32'h0500_66b4, "arb flag");
        wr(OFF_STATUS, 32'h0400_0000);
        rchk(OFF_STATUS, 32'h0100_66b4, "arb flag cleared");
        summarize();
    end
endmodule : tb_top
